//--- bihp_pkg.sv
// Shared constants, field layouts and carrier types for the banked IO host port.
// Assumes one 20 MHz clock and a synchronous active-low reset in every user.
package bihp_pkg;

	// -------------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------------
	localparam int CLK_NS        = 50;
	localparam int MEM_ACCESS_NS = 100;
	localparam int MEM_CYCLES    = (MEM_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] MEM_WR_LOAD = 3'(MEM_CYCLES - 1);
	localparam logic [2:0] MEM_RD_LOAD = 3'(MEM_CYCLES + 1);

	// -------------------------------------------------------------------------
	// Register offsets within a bank
	// -------------------------------------------------------------------------
	localparam logic [3:0] OFS_CMD          = 4'h0;
	localparam logic [3:0] OFS_IO_WINDOW    = 4'h3;
	localparam logic [3:0] OFS_STEPPING     = 4'ha;
	localparam logic [3:0] OFS_RX_NORES     = 4'hb;
	localparam logic [3:0] OFS_HOST_ADDR_LO = 4'hc;
	localparam logic [3:0] OFS_HOST_ADDR_HI = 4'hd;
	localparam logic [3:0] OFS_MEM_PORT_LO  = 4'he;
	localparam logic [3:0] OFS_MEM_PORT_HI  = 4'hf;

	// -------------------------------------------------------------------------
	// Banks and command field
	// -------------------------------------------------------------------------
	localparam logic [1:0] BANK0           = 2'b00;
	localparam logic [1:0] BANK1           = 2'b01;
	localparam logic [1:0] BANK2           = 2'b10;
	localparam logic [1:0] BANK_NONE       = 2'b11;
	localparam logic [4:0] CMD_SWITCH_BANK = 5'h00;
	localparam int         NUM_REGS        = 48;
	localparam logic [5:0] IDX_IO_WINDOW   = {BANK1, OFS_IO_WINDOW};

	// -------------------------------------------------------------------------
	// Values after reset, host address step and stepping code
	// -------------------------------------------------------------------------
	localparam logic [5:0]  RST_IO_WINDOW = 6'h30;
	localparam logic [15:0] RST_HOST_ADDR = 16'h0000;
	localparam logic [15:0] HADDR_STEP    = 16'h0002;
	localparam logic [2:0]  STEPPING_CODE = 3'h1;

	// Readable bits per register, register 15 in the top byte
	localparam logic [127:0] B0_READ_MASK = {16{8'hff}};
	localparam logic [127:0] B1_READ_MASK = {8'h00, 8'h00, 8'h04, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h3f, 8'hff, 8'h82, 8'hff};
	localparam logic [127:0] B2_READ_MASK = {8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h1f,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'he1, 8'hff};

	// -------------------------------------------------------------------------
	// Carriers and states
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic        aen;
		logic        iorn;
		logic        iown;
		logic [9:0]  sa;
		logic [15:0] sd;
	} bihp_isa_t;

	localparam bihp_isa_t ISA_IDLE = '{aen: 1'b1, iorn: 1'b1, iown: 1'b1,
		sa: 10'h000, sd: 16'h0000};

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} bihp_mem_wr_t;

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_RD   = 5'b00010,
		H_WR   = 5'b00100,
		H_MWR  = 5'b01000,
		H_MRD  = 5'b10000
	} bihp_host_state_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_WR   = 3'b010,
		M_RD   = 3'b100
	} bihp_mem_state_t;

endpackage : bihp_pkg

//--- bihp_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the group is quasi-static around the events that the user samples.
`timescale 1ns/10ps
module bihp_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] stage1;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			stage1 <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end

endmodule : bihp_sync

//--- bihp_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
// Assumes one clock; full and empty are exact, no bypass path.
`timescale 1ns/10ps
module bihp_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule : bihp_fifo

//--- bihp_host_port.sv
// Banked IO host port: relocatable 16-address register window, three banks,
// shared command register and an auto-incrementing local memory port.
// Assumes ISA IO strobes and address arrive asynchronously on pins, and that
// the local memory arbiter grants access through mem_grant.
//
// How it works
// - Sixteen consecutive IO addresses select registers
// - Window base anywhere in 1 KB IO space
// - Active bank holds until host switches it
// - Bank switch written via register zero, any bank
// - Command register identical at offset zero everywhere
// - Whole local memory behind one 16-bit port
// - Device decodes, handshakes and drives memory signals
// - Address advances after each memory write
// - Address advances after each memory read
// - Same port address, only internal address moves
// - Field 00/01/10 selects bank 0/1/2
// - Bank field used only with switch command
// - Reset makes bank zero active
// - Command read returns the active bank
`timescale 1ns/10ps
module bihp_host_port #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// ISA IO cycle pins
	input  wire logic [9:0]  sa,
	input  wire logic        aen,
	input  wire logic        iorn,
	input  wire logic        iown,
	input  wire logic [15:0] sd_in,
	output logic      [15:0] sd_out,
	output logic             sd_oe,
	output logic             io_ready,
	// Local memory
	input  wire logic        mem_grant,
	output logic      [15:0] mem_addr,
	input  wire logic [15:0] mem_d_in,
	output logic      [15:0] mem_d_out,
	output logic             mem_d_oe,
	output logic             mem_csn,
	output logic             mem_oen,
	output logic             mem_wen,
	// Device side
	input  wire logic [7:0]  rx_nores_count,
	output logic             cmd_strobe,
	output logic      [7:0]  cmd_code,
	output logic      [1:0]  active_bank,
	output logic      [5:0]  io_window
);

	// -------------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------------
	bihp_pkg::bihp_isa_t isa_raw;
	bihp_pkg::bihp_isa_t s_isa;
	logic [15:0]         s_mem_d;

	assign isa_raw = '{aen: aen, iorn: iorn, iown: iown, sa: sa, sd: sd_in};

	bihp_sync #(
		.W       ($bits(bihp_pkg::bihp_isa_t)),
		.RST_VAL (bihp_pkg::ISA_IDLE)
	) u_isa_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (isa_raw),
		.q      (s_isa)
	);

	// Memory data is a pin too; its two stages are folded into the read wait
	bihp_sync #(
		.W       (16),
		.RST_VAL (16'h0000)
	) u_mem_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (mem_d_in),
		.q      (s_mem_d)
	);

	// -------------------------------------------------------------------------
	// Strobe edges and window decode
	// -------------------------------------------------------------------------
	logic       prev_iorn;
	logic       prev_iown;
	logic       rd_fall;
	logic       rd_rise;
	logic       wr_fall;
	logic       wr_rise;
	logic       sel;
	logic [3:0] ofs;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prev_iorn <= 1'b1;
			prev_iown <= 1'b1;
		end else begin
			prev_iorn <= s_isa.iorn;
			prev_iown <= s_isa.iown;
		end
	end

	assign rd_fall = prev_iorn && !s_isa.iorn;
	assign rd_rise = !prev_iorn && s_isa.iorn;
	assign wr_fall = prev_iown && !s_isa.iown;
	assign wr_rise = !prev_iown && s_isa.iown;
	assign ofs     = s_isa.sa[3:0];
	// DMA cycles (aen high) never hit the window
	assign sel     = !s_isa.aen && (s_isa.sa[9:4] == io_window);

	// -------------------------------------------------------------------------
	// Host cycle sequencer
	// -------------------------------------------------------------------------
	bihp_pkg::bihp_host_state_t hstate;
	logic [3:0]                 cyc_ofs;
	logic [1:0]                 cyc_bank;
	logic                       cyc_mem;
	logic [15:0]                wdata;
	logic                       fifo_in_valid;
	logic                       fifo_in_ready;
	logic                       fifo_push;
	logic                       reg_wr;
	logic                       rd_done;
	logic [15:0]                rd_data;
	logic [1:0]                 bank;
	logic [15:0]                haddr;

	assign cyc_mem = (cyc_bank == bihp_pkg::BANK0) &&
		((cyc_ofs == bihp_pkg::OFS_MEM_PORT_LO) || (cyc_ofs == bihp_pkg::OFS_MEM_PORT_HI));

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			hstate <= bihp_pkg::H_IDLE;
		end else begin
			case (hstate)
				bihp_pkg::H_IDLE: begin
					if (rd_fall && sel) begin
						hstate <= (bank == bihp_pkg::BANK0 &&
							ofs[3:1] == bihp_pkg::OFS_MEM_PORT_LO[3:1]) ?
							bihp_pkg::H_MRD : bihp_pkg::H_RD;
					end else if (wr_fall && sel) begin
						hstate <= bihp_pkg::H_WR;
					end
				end
				bihp_pkg::H_RD: begin
					if (rd_rise) begin
						hstate <= bihp_pkg::H_IDLE;
					end
				end
				bihp_pkg::H_MRD: begin
					if (rd_done) begin
						hstate <= bihp_pkg::H_RD;
					end
				end
				bihp_pkg::H_WR: begin
					if (wr_rise) begin
						hstate <= (cyc_mem && !fifo_in_ready) ?
							bihp_pkg::H_MWR : bihp_pkg::H_IDLE;
					end
				end
				bihp_pkg::H_MWR: begin
					if (fifo_in_ready) begin
						hstate <= bihp_pkg::H_IDLE;
					end
				end
				default: begin
					hstate <= bihp_pkg::H_IDLE;
				end
			endcase
		end
	end

	// Offset and bank are frozen for the whole cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cyc_ofs  <= 4'h0;
			cyc_bank <= bihp_pkg::BANK0;
		end else if (hstate == bihp_pkg::H_IDLE && (rd_fall || wr_fall) && sel) begin
			cyc_ofs  <= ofs;
			cyc_bank <= bank;
		end
	end

	// Data sampled while the write strobe is low, used once it rises
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wdata <= 16'h0000;
		end else if (hstate == bihp_pkg::H_WR && !s_isa.iown) begin
			wdata <= s_isa.sd;
		end
	end

	assign reg_wr        = (hstate == bihp_pkg::H_WR) && wr_rise && !cyc_mem;
	assign fifo_in_valid = cyc_mem &&
		(((hstate == bihp_pkg::H_WR) && wr_rise) || (hstate == bihp_pkg::H_MWR));
	assign fifo_push     = fifo_in_valid && fifo_in_ready;
	// A full buffer or a pending memory read stretches the host cycle
	assign io_ready = (hstate != bihp_pkg::H_MRD) && (hstate != bihp_pkg::H_MWR) &&
		!((hstate == bihp_pkg::H_WR) && cyc_mem && !fifo_in_ready);

	// -------------------------------------------------------------------------
	// Register file
	// -------------------------------------------------------------------------
	logic [7:0] store [bihp_pkg::NUM_REGS];
	logic [4:0] cmd_opcode;
	logic [7:0] reg_rdata;
	logic [7:0] rmask;
	logic [5:0] widx;
	logic       cmd_wr;
	logic [1:0] wr_ptr_field;

	assign widx         = {cyc_bank, cyc_ofs};
	assign cmd_wr       = reg_wr && (cyc_ofs == bihp_pkg::OFS_CMD);
	assign wr_ptr_field = wdata[7:6];
	assign io_window    = store[bihp_pkg::IDX_IO_WINDOW][5:0];
	assign active_bank  = bank;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			for (int i = 0; i < bihp_pkg::NUM_REGS; i++) begin
				store[i] <= (i == int'(bihp_pkg::IDX_IO_WINDOW)) ?
					{2'b00, bihp_pkg::RST_IO_WINDOW} : 8'h00;
			end
		end else if (reg_wr && cyc_ofs != bihp_pkg::OFS_CMD) begin
			store[widx] <= wdata[7:0];
		end
	end

	// Reserved field codes leave the bank where it is
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bank <= bihp_pkg::BANK0;
		end else if (cmd_wr && wdata[4:0] == bihp_pkg::CMD_SWITCH_BANK &&
				wr_ptr_field != bihp_pkg::BANK_NONE) begin
			bank <= wr_ptr_field;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cmd_opcode <= 5'h00;
			cmd_strobe <= 1'b0;
			cmd_code   <= 8'h00;
		end else begin
			cmd_strobe <= cmd_wr;
			if (cmd_wr) begin
				cmd_opcode <= wdata[4:0];
				cmd_code   <= wdata[7:0];
			end
		end
	end

	always_comb begin
		if (bank == bihp_pkg::BANK1) begin
			rmask = bihp_pkg::B1_READ_MASK[ofs*8 +: 8];
		end else if (bank == bihp_pkg::BANK2) begin
			rmask = bihp_pkg::B2_READ_MASK[ofs*8 +: 8];
		end else begin
			rmask = bihp_pkg::B0_READ_MASK[ofs*8 +: 8];
		end
	end

	always_comb begin
		if (ofs == bihp_pkg::OFS_CMD) begin
			reg_rdata = {bank, 1'b0, cmd_opcode};
		end else if (bank == bihp_pkg::BANK0 && ofs == bihp_pkg::OFS_HOST_ADDR_LO) begin
			reg_rdata = haddr[7:0];
		end else if (bank == bihp_pkg::BANK0 && ofs == bihp_pkg::OFS_HOST_ADDR_HI) begin
			reg_rdata = haddr[15:8];
		end else if (bank == bihp_pkg::BANK2 && ofs == bihp_pkg::OFS_RX_NORES) begin
			reg_rdata = rx_nores_count;
		end else if (bank == bihp_pkg::BANK2 && ofs == bihp_pkg::OFS_STEPPING) begin
			reg_rdata = {bihp_pkg::STEPPING_CODE, store[{bank, ofs}][4:0] & rmask[4:0]};
		end else begin
			reg_rdata = store[{bank, ofs}] & rmask;
		end
	end

	// -------------------------------------------------------------------------
	// Host address register
	// -------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			haddr <= bihp_pkg::RST_HOST_ADDR;
		end else if (fifo_push || rd_done) begin
			haddr <= haddr + bihp_pkg::HADDR_STEP;
		end else if (reg_wr && cyc_bank == bihp_pkg::BANK0 &&
				cyc_ofs == bihp_pkg::OFS_HOST_ADDR_LO) begin
			haddr[7:0] <= wdata[7:0];
		end else if (reg_wr && cyc_bank == bihp_pkg::BANK0 &&
				cyc_ofs == bihp_pkg::OFS_HOST_ADDR_HI) begin
			haddr[15:8] <= wdata[7:0];
		end
	end

	// -------------------------------------------------------------------------
	// Host read data
	// -------------------------------------------------------------------------
	// Drive releases two to three cycles after the strobe rises at the pin
	assign sd_oe = (hstate == bihp_pkg::H_RD);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sd_out <= 16'h0000;
		end else if (hstate == bihp_pkg::H_IDLE && rd_fall && sel) begin
			sd_out <= {8'h00, reg_rdata};
		end else if (rd_done) begin
			sd_out <= rd_data;
		end
	end

	// -------------------------------------------------------------------------
	// Posted write buffer
	// -------------------------------------------------------------------------
	bihp_pkg::bihp_mem_wr_t fifo_in;
	bihp_pkg::bihp_mem_wr_t fifo_out;
	logic                   fifo_out_valid;
	logic                   fifo_out_ready;

	assign fifo_in = '{addr: haddr, data: wdata};

	bihp_fifo #(
		.W     ($bits(bihp_pkg::bihp_mem_wr_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	// -------------------------------------------------------------------------
	// Local memory sequencer
	// -------------------------------------------------------------------------
	bihp_pkg::bihp_mem_state_t mstate;
	logic [2:0]                mcnt;
	logic                      rd_req;
	logic                      rd_go;

	assign rd_req         = (hstate == bihp_pkg::H_MRD);
	// Reads wait for posted writes so data never overtakes them
	assign fifo_out_ready = (mstate == bihp_pkg::M_IDLE) && mem_grant;
	// The cycle that finishes a read still shows H_MRD; it must not launch a second read
	assign rd_go          = fifo_out_ready && !fifo_out_valid && rd_req && !rd_done;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mstate    <= bihp_pkg::M_IDLE;
			mcnt      <= 3'h0;
			mem_addr  <= 16'h0000;
			mem_d_out <= 16'h0000;
			mem_d_oe  <= 1'b0;
			mem_csn   <= 1'b1;
			mem_oen   <= 1'b1;
			mem_wen   <= 1'b1;
			rd_done   <= 1'b0;
			rd_data   <= 16'h0000;
		end else begin
			rd_done <= 1'b0;
			case (mstate)
				bihp_pkg::M_IDLE: begin
					if (fifo_out_ready && fifo_out_valid) begin
						mstate    <= bihp_pkg::M_WR;
						mcnt      <= bihp_pkg::MEM_WR_LOAD;
						mem_addr  <= fifo_out.addr;
						mem_d_out <= fifo_out.data;
						mem_d_oe  <= 1'b1;
						mem_csn   <= 1'b0;
						mem_wen   <= 1'b0;
					end else if (rd_go) begin
						mstate   <= bihp_pkg::M_RD;
						mcnt     <= bihp_pkg::MEM_RD_LOAD;
						mem_addr <= haddr;
						mem_csn  <= 1'b0;
						mem_oen  <= 1'b0;
					end
				end
				bihp_pkg::M_WR: begin
					if (mcnt == 3'h0) begin
						mstate   <= bihp_pkg::M_IDLE;
						mem_csn  <= 1'b1;
						mem_wen  <= 1'b1;
						mem_d_oe <= 1'b0;
					end else begin
						mcnt <= mcnt - 3'h1;
					end
				end
				bihp_pkg::M_RD: begin
					if (mcnt == 3'h0) begin
						mstate  <= bihp_pkg::M_IDLE;
						mem_csn <= 1'b1;
						mem_oen <= 1'b1;
						rd_data <= s_mem_d;
						rd_done <= 1'b1;
					end else begin
						mcnt <= mcnt - 3'h1;
					end
				end
				default: begin
					mstate <= bihp_pkg::M_IDLE;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	property p_reset_bank;
		$past(!resetn) |-> (bank == bihp_pkg::BANK0);
	endproperty
	a_reset_bank: assert property (p_reset_bank) else $error("bank not zero after reset");

	property p_bank_switch;
		(cmd_wr && wdata[4:0] == bihp_pkg::CMD_SWITCH_BANK && wr_ptr_field != 2'b11)
			|=> (bank == $past(wr_ptr_field));
	endproperty
	a_bank_switch: assert property (p_bank_switch) else $error("bank switch lost");

	property p_bank_ignore;
		(cmd_wr && wdata[4:0] != bihp_pkg::CMD_SWITCH_BANK) |=> $stable(bank);
	endproperty
	a_bank_ignore: assert property (p_bank_ignore) else $error("field used by other cmd");

	property p_bank_hold;
		!cmd_wr |=> $stable(bank);
	endproperty
	a_bank_hold: assert property (p_bank_hold) else $error("bank moved without command");

	property p_cmd_read;
		(hstate == bihp_pkg::H_IDLE && rd_fall && sel && ofs == 4'h0)
			|=> (sd_out[7:6] == $past(bank)) && (hstate == bihp_pkg::H_RD);
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("command read lacks bank");

	property p_outside_window;
		(hstate == bihp_pkg::H_IDLE && (rd_fall || wr_fall) && !sel)
			|=> (hstate == bihp_pkg::H_IDLE) && !sd_oe;
	endproperty
	a_outside_window: assert property (p_outside_window) else $error("decoded foreign addr");

	property p_wr_inc;
		fifo_push |=> (haddr == $past(haddr) + bihp_pkg::HADDR_STEP);
	endproperty
	a_wr_inc: assert property (p_wr_inc) else $error("no advance after write");

	property p_rd_inc;
		rd_done |=> (haddr == $past(haddr) + bihp_pkg::HADDR_STEP) && sd_out == $past(rd_data);
	endproperty
	a_rd_inc: assert property (p_rd_inc) else $error("no advance after read");

	property p_mem_read;
		rd_go |=> (!mem_csn && !mem_oen && mem_addr == $past(haddr)) ##[1:8] rd_done;
	endproperty
	a_mem_read: assert property (p_mem_read) else $error("memory read not driven");

	property p_mem_write;
		(fifo_out_ready && fifo_out_valid) |=> (!mem_wen && !mem_csn && mem_d_oe &&
			mem_addr == $past(fifo_out.addr) && mem_d_out == $past(fifo_out.data))
			##1 !mem_wen ##1 (mem_wen && mem_csn && !mem_d_oe);
	endproperty
	a_mem_write: assert property (p_mem_write) else $error("memory write not driven");

endmodule : bihp_host_port

//--- bihp_sram_model.sv
// Local SRAM model behind the memory pins of the banked IO host port.
// Assumes word storage at byte address bit 1 up and one shared clock.
`timescale 1ns/10ps
module bihp_sram_model (
	// Clock
	input  wire logic        mclk,
	// Memory pins
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_d_out,
	input  wire logic        mem_csn,
	input  wire logic        mem_oen,
	input  wire logic        mem_wen,
	output logic      [15:0] mem_d_in
);
	logic [15:0] ram [0:32767];
	logic [15:0] last = 16'h0000;

	always @(posedge mclk) begin
		if (!mem_csn && !mem_wen)
			ram[mem_addr[15:1]] <= mem_d_out;
		if (!mem_csn && !mem_oen)
			last <= ram[mem_addr[15:1]];
	end

	// Released bus shows the inverse of the last word, never a stale copy
	assign mem_d_in = (!mem_csn && !mem_oen) ? ram[mem_addr[15:1]] : ~last;
endmodule : bihp_sram_model

//--- bihp_host_port_tb.sv
// Self-checking bench for the banked IO host port.
// Assumes the SRAM model on the memory pins and a 20 MHz clock.
`timescale 1ns/10ps
module bihp_host_port_tb;
	logic        mclk = 0, resetn = 0, aen = 1, iorn = 1, iown = 1, mem_grant = 0, rg = 0;
	logic [9:0]  sa = 0;
	logic [15:0] sd_in = 0, sd_out, mem_addr, mem_d_in, mem_d_out, base, hw;
	logic        sd_oe, io_ready, mem_d_oe, mem_csn, mem_oen, mem_wen, cmd_strobe, oe_q;
	logic [7:0]  cmd_code;
	logic [1:0]  active_bank;
	logic [5:0]  io_window, win = 6'h30;
	logic [15:0] expq[$], data[0:32];
	int          err_count = 0, n_compared = 0, seed = 26, n_strobe = 0;

	always #25 mclk = ~mclk;

	bihp_host_port #(.FIFO_DEPTH(32)) DUT (.mclk(mclk), .resetn(resetn), .sa(sa), .aen(aen),
		.iorn(iorn), .iown(iown), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
		.io_ready(io_ready), .mem_grant(mem_grant), .mem_addr(mem_addr), .mem_d_in(mem_d_in),
		.mem_d_out(mem_d_out), .mem_d_oe(mem_d_oe), .mem_csn(mem_csn), .mem_oen(mem_oen),
		.mem_wen(mem_wen), .rx_nores_count(8'h5a), .cmd_strobe(cmd_strobe),
		.cmd_code(cmd_code), .active_bank(active_bank), .io_window(io_window));
	bihp_sram_model SRAM (.mclk(mclk), .mem_addr(mem_addr), .mem_d_out(mem_d_out),
		.mem_csn(mem_csn), .mem_oen(mem_oen), .mem_wen(mem_wen), .mem_d_in(mem_d_in));

	// -------------------------------------------------------------------------
	// Bus tasks and read monitor
	// -------------------------------------------------------------------------
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk

	// Strobe held until io_ready is high, so a full FIFO stalls the host here
	task cyc(input logic wr, input logic [3:0] ofs, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		sa = {win, ofs};
		aen = 0;
		sd_in = d;
		iown = !wr;
		iorn = wr;
		repeat (4) @(negedge mclk);
		while (io_ready !== 1'b1 && n < 1000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 1000) chk("io_ready", 16'h0001, 16'h0000);
		iown = 1;
		iorn = 1;
		repeat (5) @(negedge mclk);
	endtask : cyc

	task rd(input logic [3:0] ofs, input logic [15:0] e);
		expq.push_back(e);
		cyc(0, ofs, 16'h0000);
	endtask : rd

	always @(negedge mclk) begin
		if (sd_oe === 1'b1 && oe_q !== 1'b1) begin
			if (expq.size() == 0) chk("sd_oe", 16'h0000, 16'h0001);
			else chk("read data", expq.pop_front(), sd_out);
		end
		if (cmd_strobe === 1'b1) n_strobe++;
		oe_q = sd_oe;
	end

	always @(negedge mclk) if (rg) mem_grant = 1'($random(seed));

	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	initial begin
		#1000000;
		err_count++;
		tally_and_finish;
	end

	initial begin
		repeat (3) @(negedge mclk);
		resetn = 1;
		repeat (4) @(negedge mclk);
		chk("active_bank", 16'h0000, {14'h0, active_bank});
		chk("io_window", 16'h0030, {10'h0, io_window});
		rd(4'h0, 16'h0000);
		for (int b = 0; b < 3; b++) begin
			cyc(1, 4'h0, {8'h0, 2'(b), 6'h00});
			chk("active_bank", 16'(b), {14'h0, active_bank});
			cyc(1, 4'h0, 16'h00c0);
			cyc(1, 4'h0, {8'h0, 2'(b ^ 1), 6'h01});
			chk("active_bank", 16'(b), {14'h0, active_bank});
			chk("cmd_code", {8'h0, 2'(b ^ 1), 6'h01}, {8'h0, cmd_code});
			rd(4'h0, {8'h0, 2'(b), 6'h01});
		end
		rd(4'hb, 16'h005a);
		hw = 16'($random(seed));
		cyc(1, 4'h8, {8'h0, hw[7:0]});
		cyc(1, 4'h0, 16'h0040);
		cyc(1, 4'h8, {8'h0, hw[15:8]});
		rd(4'h8, {8'h0, hw[15:8]});
		cyc(1, 4'h0, 16'h0080);
		rd(4'h8, {8'h0, hw[7:0]});
		cyc(1, 4'h0, 16'h0040);
		hw[5:0] = 6'h30 ^ (6'($random(seed)) | 6'h01);
		cyc(1, 4'h3, {10'h0, hw[5:0]});
		chk("io_window", {10'h0, hw[5:0]}, {10'h0, io_window});
		cyc(1, 4'h0, 16'h0000);
		chk("active_bank", 16'h0001, {14'h0, active_bank});
		win = hw[5:0];
		cyc(1, 4'h0, 16'h0000);
		chk("active_bank", 16'h0000, {14'h0, active_bank});
		base = {8'($random(seed)), 8'h00};
		cyc(1, 4'hc, {8'h0, base[7:0]});
		cyc(1, 4'hd, {8'h0, base[15:8]});
		// Grant withheld so the FIFO fills and the last write is refused a while
		fork
			begin
				repeat (500) @(negedge mclk);
				mem_grant = 1;
			end
		join_none
		for (int i = 0; i < 33; i++) begin
			data[i] = 16'($random(seed));
			cyc(1, 4'he, data[i]);
		end
		rd(4'hc, {8'h0, 8'(base[7:0] + 8'h42)});
		rg = 1;
		cyc(1, 4'hc, {8'h0, base[7:0]});
		for (int i = 0; i < 33; i++) rd(i[0] ? 4'hf : 4'he, data[i]);
		rd(4'hc, {8'h0, 8'(base[7:0] + 8'h42)});
		rd(4'hd, {8'h0, base[15:8]});
		repeat (10) @(negedge mclk);
		chk("pending reads", 16'h0000, 16'(expq.size()));
		chk("cmd_strobe", 16'h000d, 16'(n_strobe));
		tally_and_finish;
	end
endmodule : bihp_host_port_tb
